// File: src/ccb_params.svh
`ifndef CCB_PARAMS_SVH
`define CCB_PARAMS_SVH

`define CCB_ADDR_CTRL 8'h06
`define CCB_ADDR_PEER 8'h07
`define CCB_ADDR_MAP0 8'h08

`define CCB_CTRL_RESET 8'h00
`define CCB_PEER_RESET 8'h00
`define CCB_MAP0_RESET 8'h00

`define CCB_SEQ_ERR_BIT 7
`define CCB_SEQ_CLR_BIT 6
`define CCB_SDA_DLY_HI 4
`define CCB_SDA_DLY_LO 3
`define CCB_WR_BLOCK_BIT 2
`define CCB_WD_FAST_BIT 1
`define CCB_WD_DIS_BIT 0
`define CCB_ID_HI 7
`define CCB_ID_LO 1
`define CCB_FREEZE_BIT 0

`define CCB_CLK_MHZ 100
`define CCB_CLK_NS 10
`define CCB_WD_FAST_US 50
`define CCB_WD_FAST_CYC (`CCB_WD_FAST_US * `CCB_CLK_MHZ)
`define CCB_WD_SLOW_S 1
`define CCB_WD_SLOW_CYC (`CCB_WD_SLOW_S * `CCB_CLK_MHZ * 1000000)
`define CCB_SDA_BASE_NS 250
`define CCB_SDA_STEP_NS 50
`define CCB_RCV_HALF_NS 5000
`define CCB_RCV_HALF_CYC ((`CCB_RCV_HALF_NS + `CCB_CLK_NS - 1) / `CCB_CLK_NS)
`define CCB_RCV_PULSES 9

`endif

// File: src/ccb_pkg.sv
package ccb_pkg;

    typedef struct packed {
        logic wr;
        logic rd;
        logic remote;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ccb_reg_req_t;

    typedef struct packed {
        logic valid;
        logic [6:0] addr;
    } ccb_txn_t;

    typedef struct packed {
        logic valid;
        logic to_ser;
        logic [6:0] addr;
    } ccb_fwd_t;

    typedef enum logic [1:0] {
        CCB_WD_MON = 2'h0,
        CCB_WD_LOW = 2'h1,
        CCB_WD_HIGH = 2'h3
    } ccb_wd_state_t;

endpackage

// File: src/ccb_bus_watchdog.sv
`timescale 1ns/100ps
`default_nettype none
`include "ccb_params.svh"

module ccb_bus_watchdog
    import ccb_pkg::*;
#(
    parameter int FAST_CYC = `CCB_WD_FAST_CYC,
    parameter int SLOW_CYC = `CCB_WD_SLOW_CYC,
    parameter int CW = 27
)
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic scl_s,
    input wire logic sda_s,
    input wire logic enable,
    input wire logic fast,
    output logic bus_free,
    output logic scl_oe,
    output logic recovering
);

    localparam int HALF = `CCB_RCV_HALF_CYC;
    localparam int PULSES = `CCB_RCV_PULSES;

    ccb_wd_state_t state;
    ccb_wd_state_t next_state;
    logic [CW-1:0] cnt;
    logic [CW-1:0] next_cnt;
    logic [9:0] half_cnt;
    logic [9:0] next_half_cnt;
    logic [3:0] pulses;
    logic [3:0] next_pulses;
    logic next_free;
    logic scl_d;
    logic sda_d;

    wire activity = (scl_s != scl_d) | (sda_s != sda_d);
    wire [CW-1:0] limit = fast ? CW'(FAST_CYC - 1) : CW'(SLOW_CYC - 1);
    wire expired = cnt >= limit;
    wire half_done = half_cnt == 10'(HALF - 1);
    wire last_pulse = pulses == 4'(PULSES - 1);

    always_comb
    begin
        next_state = state;
        next_cnt = cnt;
        next_half_cnt = half_cnt + 10'h001;
        next_pulses = pulses;
        next_free = bus_free;
        case (state)
            CCB_WD_MON:
            begin
                next_half_cnt = 10'h000;
                next_pulses = 4'h0;
                if (activity)
                begin
                    next_cnt = '0;
                    next_free = 1'b0;
                end
                else if (!expired)
                    next_cnt = cnt + CW'(1);
                else if (sda_s)
                    next_free = 1'b1;
                else
                begin
                    next_state = CCB_WD_LOW;
                    next_cnt = '0;
                end
            end
            CCB_WD_LOW:
                if (half_done)
                begin
                    next_state = CCB_WD_HIGH;
                    next_half_cnt = 10'h000;
                end
            CCB_WD_HIGH:
                if (half_done)
                begin
                    next_half_cnt = 10'h000;
                    if (last_pulse)
                        next_state = CCB_WD_MON;
                    else
                    begin
                        next_pulses = pulses + 4'h1;
                        next_state = CCB_WD_LOW;
                    end
                end
            default:
                next_state = CCB_WD_MON;
        endcase
        // Disabled watchdog neither watches nor recovers
        if (!enable)
        begin
            next_state = CCB_WD_MON;
            next_cnt = '0;
            next_free = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state <= CCB_WD_MON;
            cnt <= '0;
            half_cnt <= 10'h000;
            pulses <= 4'h0;
            bus_free <= 1'b0;
            scl_oe <= 1'b0;
            recovering <= 1'b0;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end
        else
        begin
            state <= next_state;
            cnt <= next_cnt;
            half_cnt <= next_half_cnt;
            pulses <= next_pulses;
            bus_free <= next_free;
            scl_oe <= next_state == CCB_WD_LOW;
            recovering <= next_state != CCB_WD_MON;
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

endmodule

`default_nettype wire

// File: src/ccb_bridge_cfg.sv
// Overview of operation
// - Forward channel sequence error sets read-only flag bit 7 of control.
// - Writing one to control bit 6 clears the sequence error flag.
// - Bits 4-3 pick SDA delay 250ns plus 50ns per step after SCL.
// - Local write block bit 2 drops register writes from remote side.
// - Write block leaves remote access to local I2C targets untouched.
// - Watchdog timeout about 50us with bit 1 set, else about 1s.
// - Bit 0 set disables the bus watchdog and its recovery.
// - SDA high and bus idle for timeout marks the bus free.
// - SDA low and bus idle for timeout sends nine SCL pulses.
// - Peer address bits 7-1 hold serializer ID; zero blocks access.
// - After receive lock the serializer ID auto-loads unless frozen.
// - Freeze bit 0 stops auto-load and keeps the software value.
// - Alias 0 transactions are readdressed to map 0 bits 7-1.
`timescale 1ns/100ps
`default_nettype none
`include "ccb_params.svh"

module ccb_bridge_cfg
    import ccb_pkg::*;
#(
    parameter int WD_FAST_CYC = `CCB_WD_FAST_CYC,
    parameter int WD_SLOW_CYC = `CCB_WD_SLOW_CYC
)
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire ccb_reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    input wire logic seq_err_evt,
    input wire logic rx_lock,
    input wire logic ser_id_valid,
    input wire logic [6:0] ser_id,
    input wire logic [6:0] target_alias_0,
    input wire ccb_txn_t txn,
    output ccb_fwd_t fwd,
    input wire logic sda_drive_low,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    output logic bus_free,
    output logic bus_recovering
);

    logic seq_err;
    logic seq_clr;
    logic [1:0] sda_dly;
    logic wr_block;
    logic wd_fast;
    logic wd_dis;
    logic [6:0] peer_serializer_address;
    logic peer_address_freeze;
    logic [6:0] remote_target_phys_addr_0;
    logic [1:0] pin_meta;
    logic [1:0] pin_sync;
    logic scl_prev;
    logic [5:0] dly_cnt;
    logic dly_armed;

    wire scl_s = pin_sync[1];
    wire sda_s = pin_sync[0];

    // Only the register write path is gated; pass-through traffic is not
    wire wr_ok = reg_req.wr & ~(reg_req.remote & wr_block);
    wire wr_ctrl = wr_ok & (reg_req.addr == `CCB_ADDR_CTRL);
    wire wr_peer = wr_ok & (reg_req.addr == `CCB_ADDR_PEER);
    wire wr_map0 = wr_ok & (reg_req.addr == `CCB_ADDR_MAP0);
    wire clr_req = wr_ctrl & reg_req.wdata[`CCB_SEQ_CLR_BIT];

    // Set wins over a clear in the same cycle
    wire next_seq_err = seq_err_evt | (seq_err & ~clr_req);

    // A software write in the same cycle beats the auto-load
    wire auto_load = rx_lock & ser_id_valid & ~peer_address_freeze
        & ~wr_peer;

    wire [7:0] ctrl_rd = {seq_err, seq_clr, 1'b0, sda_dly, wr_block,
        wd_fast, wd_dis};
    wire [7:0] peer_rd = {peer_serializer_address, peer_address_freeze};
    wire [7:0] map0_rd = {remote_target_phys_addr_0, 1'b0};
    wire [7:0] next_rdata =
        (reg_req.addr == `CCB_ADDR_CTRL) ? ctrl_rd :
        (reg_req.addr == `CCB_ADDR_PEER) ? peer_rd :
        (reg_req.addr == `CCB_ADDR_MAP0) ? map0_rd : 8'h00;

    wire is_alias_0 = txn.addr == target_alias_0;
    wire [6:0] fwd_addr = is_alias_0 ? remote_target_phys_addr_0
        : txn.addr;
    wire to_ser = (fwd_addr == peer_serializer_address)
        & (peer_serializer_address != 7'h00);

    wire [5:0] dly_cyc = 6'((`CCB_SDA_BASE_NS + `CCB_SDA_STEP_NS
        * int'(sda_dly) + `CCB_CLK_NS - 1) / `CCB_CLK_NS);
    wire scl_fall = scl_prev & ~scl_s;
    wire dly_done = dly_armed & (dly_cnt == 6'h00);

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pin_meta <= 2'h3;
            pin_sync <= 2'h3;
            scl_prev <= 1'b1;
        end
        else
        begin
            pin_meta <= {scl_i, sda_i};
            pin_sync <= pin_meta;
            scl_prev <= scl_s;
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            seq_err <= 1'b0;
        else
            seq_err <= next_seq_err;
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            {seq_clr, sda_dly, wr_block, wd_fast, wd_dis} <=
                6'(`CCB_CTRL_RESET);
        else if (wr_ctrl)
            {seq_clr, sda_dly, wr_block, wd_fast, wd_dis} <=
                {reg_req.wdata[`CCB_SEQ_CLR_BIT],
                reg_req.wdata[`CCB_SDA_DLY_HI:`CCB_SDA_DLY_LO],
                reg_req.wdata[`CCB_WR_BLOCK_BIT],
                reg_req.wdata[`CCB_WD_FAST_BIT],
                reg_req.wdata[`CCB_WD_DIS_BIT]};
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            {peer_serializer_address, peer_address_freeze} <= `CCB_PEER_RESET;
        else if (wr_peer)
            {peer_serializer_address, peer_address_freeze} <=
                {reg_req.wdata[`CCB_ID_HI:`CCB_ID_LO],
                reg_req.wdata[`CCB_FREEZE_BIT]};
        else if (auto_load)
            peer_serializer_address <= ser_id;
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            remote_target_phys_addr_0 <= 7'(`CCB_MAP0_RESET >> 1);
        else if (wr_map0)
            remote_target_phys_addr_0 <=
                reg_req.wdata[`CCB_ID_HI:`CCB_ID_LO];
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            reg_rdata <= 8'h00;
        else if (reg_req.rd)
            reg_rdata <= next_rdata;
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            fwd <= '0;
        else
            fwd <= {txn.valid, to_ser, fwd_addr};
    end

    // Data changes only a set delay after SCL falls; a new SCL fall before the change restarts the delay
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            dly_cnt <= 6'h00;
            dly_armed <= 1'b0;
            sda_oe <= 1'b0;
            sda_o <= 1'b0;
            scl_o <= 1'b0;
        end
        else
        begin
            if (scl_fall)
            begin
                dly_cnt <= dly_cyc - 6'h03;
                dly_armed <= 1'b1;
            end
            else if (dly_done)
                dly_armed <= 1'b0;
            else if (dly_armed)
                dly_cnt <= dly_cnt - 6'h01;
            if (dly_done)
                sda_oe <= sda_drive_low;
        end
    end

    ccb_bus_watchdog #(
        .FAST_CYC(WD_FAST_CYC),
        .SLOW_CYC(WD_SLOW_CYC)
    ) u_wd (
        .core_clk(core_clk),
        .nrst(nrst),
        .scl_s(scl_s),
        .sda_s(sda_s),
        .enable(~wd_dis),
        .fast(wd_fast),
        .bus_free(bus_free),
        .scl_oe(scl_oe),
        .recovering(bus_recovering)
    );

endmodule

`default_nettype wire

// File: tb/ccb_bridge_cfg_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module ccb_bridge_cfg_chk
    import ccb_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire ccb_reg_req_t reg_req,
    input wire logic [7:0] reg_rdata,
    input wire logic seq_err_evt,
    input wire logic [6:0] target_alias_0,
    input wire ccb_txn_t txn,
    input wire ccb_fwd_t fwd,
    input wire logic sda_i,
    input wire logic scl_oe,
    input wire logic bus_free,
    input wire logic bus_recovering
);
    logic [9:0] hi_n;
    logic [3:0] np;
    logic oe_d;
    logic wdis;
    wire w6 = reg_req.wr && reg_req.addr == 8'h06;
    // Pulse width and count kept in counters, too long to unroll
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            hi_n <= '0;
            np <= '0;
            oe_d <= 1'b0;
            wdis <= 1'b0;
        end
        else
        begin
            hi_n <= scl_oe ? hi_n + 10'd1 : '0;
            np <= bus_recovering ? np + 4'(scl_oe && !oe_d) : '0;
            oe_d <= scl_oe;
            wdis <= w6 ? reg_req.wdata[0] : wdis;
        end
    end
    default clocking dc @(posedge core_clk);
    endclocking
    default disable iff (!nrst);
    sequence s_err_rd;
        seq_err_evt ##1 !reg_req.wr ##1 (reg_req.rd && reg_req.addr == 8'h06);
    endsequence
    AST_SEQ_SET: assert property (s_err_rd |=> reg_rdata[7])
        else $error("sequence flag not set");
    AST_FWD_PASS: assert property (txn.valid &&
        txn.addr != target_alias_0 |=> fwd.valid && fwd.addr == $past(txn.addr))
        else $error("address changed without alias");
    AST_PEER_ZERO: assert property (fwd.to_ser |-> fwd.addr != 7'h00)
        else $error("zero peer id reached serializer");
    AST_WD_OFF: assert property (w6 && reg_req.wdata[0] &&
        !reg_req.remote |-> ##[1:3] !scl_oe && !bus_recovering && !bus_free)
        else $error("watchdog still active");
    AST_HALF: assert property ($fell(scl_oe) && !wdis |-> hi_n == 10'd500)
        else $error("recovery pulse width");
    AST_NINE: assert property ($fell(bus_recovering) && !wdis |-> np == 4'd9)
        else $error("recovery pulse count");
    AST_OE_RCV: assert property (scl_oe |-> bus_recovering)
        else $error("scl driven outside recovery");
    AST_FREE_SDA: assert property ($rose(bus_free) |-> $past(sda_i, 4))
        else $error("free with data line low");
    AST_RCV_SDA: assert property ($rose(bus_recovering) |-> !$past(sda_i, 4))
        else $error("recovery with data line high");
endmodule
bind ccb_bridge_cfg ccb_bridge_cfg_chk chk_u (.core_clk(core_clk), .nrst(nrst),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .seq_err_evt(seq_err_evt),
    .target_alias_0(target_alias_0), .txn(txn), .fwd(fwd), .sda_i(sda_i),
    .scl_oe(scl_oe), .bus_free(bus_free), .bus_recovering(bus_recovering));
`default_nettype wire

// File: tb/ccb_i2c_peer.sv
`timescale 1ns/100ps
`default_nettype none
module ccb_i2c_peer (
    input wire logic scl_oe,
    input wire logic sda_oe,
    input wire logic hold_scl,
    input wire logic hold_sda,
    input wire logic run,
    output logic scl,
    output logic sda
);
    logic g = 1'b1;
    // 80 ns link clock, parked high between bursts
    always #40 g = run ? !g : 1'b1;
    // Pull-ups: any party may pull low
    assign scl = !(scl_oe || hold_scl || !g);
    assign sda = !(sda_oe || hold_sda);
endmodule
`default_nettype wire

// File: tb/test_ccb_bridge_cfg.sv
`timescale 1ns/100ps
`default_nettype none
module test_ccb_bridge_cfg
    import ccb_pkg::*;
;
    logic core_clk = 0, nrst = 0, evt = 0, lock = 0, idv = 0, sdl = 0, rd_d = 0;
    logic hs = 0, hd = 0, run = 0, scl, sda, scl_oe, sda_oe, bfree, brcv, o;
    logic so, sdo;
    logic [6:0] sid = '0, ali = 7'h40, peer = '0, map0 = '0;
    logic [7:0] rdat, rq_q[$], fq[$];
    logic [7:0] ra[4] = '{8'h06, 8'h07, 8'h08, 8'h09};
    logic [31:0] lf = 32'h34b5_e875;
    ccb_reg_req_t rq = '0;
    ccb_txn_t tx = '0;
    ccb_fwd_t fwd;
    int n_mismatch = 0, checks = 0;
    ccb_bridge_cfg #(.WD_FAST_CYC(50), .WD_SLOW_CYC(200)) dut_u (
        .core_clk(core_clk), .nrst(nrst), .reg_req(rq), .reg_rdata(rdat),
        .seq_err_evt(evt), .rx_lock(lock), .ser_id_valid(idv), .ser_id(sid),
        .target_alias_0(ali), .txn(tx), .fwd(fwd), .sda_drive_low(sdl),
        .scl_i(scl), .scl_o(so), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sdo),
        .sda_oe(sda_oe), .bus_free(bfree), .bus_recovering(brcv));
    ccb_i2c_peer peer_u (.scl_oe(scl_oe), .sda_oe(sda_oe), .hold_scl(hs),
        .hold_sda(hd), .run(run), .scl(scl), .sda(sda));
    task automatic wrap_up;
        if (n_mismatch == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, g);
        checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic cyc(input ccb_reg_req_t r);
        @(negedge core_clk);
        rq = r;
        @(negedge core_clk);
        rq = '0;
    endtask
    task automatic wr(input logic [7:0] a, d, input logic rem = 0);
        cyc({2'b10, rem, a, d});
    endtask
    task automatic rd(input logic [7:0] a, e);
        rq_q.push_back(e);
        cyc({3'b010, a, 8'h00});
    endtask
    task automatic pulse(ref logic s);
        @(negedge core_clk);
        s = 1;
        @(negedge core_clk);
        s = 0;
    endtask
    task automatic send(input logic [6:0] a);
        logic [6:0] m;
        m = (a == ali) ? map0 : a;
        fq.push_back({m == peer && peer != 0, m});
        @(negedge core_clk);
        tx = {1'b1, a};
        @(negedge core_clk);
        tx = '0;
    endtask
    task automatic wt(ref logic s, input logic v, input int n, output int c);
        for (c = 0; c < n && s !== v; c++)
            @(negedge core_clk);
    endtask
    always @(posedge core_clk)
        rd_d <= rq.rd;
    always @(negedge core_clk)
    begin
        if (rd_d)
            chk("rdata", rq_q.pop_front(), rdat);
        if (fwd.valid === 1'b1)
            chk("fwd", fq.pop_front(), {fwd.to_ser, fwd.addr});
    end
    initial
    begin
        forever #5 core_clk = ~core_clk;
    end
    initial
    begin
        #500000;
        n_mismatch++;
        wrap_up;
    end
    initial
    begin
        int n;
        int p;
        repeat (16) @(negedge core_clk);
        nrst = 1;
        foreach (ra[i])
            rd(ra[i], 8'h00);
        pulse(evt);
        rd(8'h06, 8'h80);
        wr(8'h06, 8'h00);
        rd(8'h06, 8'h80);
        wr(8'h06, 8'h40);
        rd(8'h06, 8'h40);
        wr(8'h06, 8'hff);
        rd(8'h06, 8'h5f);
        wr(8'h07, 8'h55, 1'b1);
        rd(8'h07, 8'h00);
        lock = 1;
        sid = 7'h2a;
        pulse(idv);
        rd(8'h07, 8'h54);
        wr(8'h07, 8'h31);
        peer = 7'h18;
        sid = 7'h11;
        pulse(idv);
        rd(8'h07, 8'h31);
        wr(8'h08, 8'h5b);
        map0 = 7'h2d;
        rd(8'h08, 8'h5a);
        send(7'h40);
        send(7'h18);
        repeat (8)
        begin
            lf = lfsr_next(lf);
            send(lf[6:0]);
        end
        wr(8'h07, 8'h01);
        peer = '0;
        send(7'h00);
        // Watchdog off so held SCL cannot start a recovery
        for (int k = 0; k < 4; k++)
        begin
            wr(8'h06, {3'b000, 2'(k), 3'b001});
            sdl = 1;
            hs = 1;
            wt(sda_oe, 1'b1, 60, n);
            if (n == 24 + 5 * k || n == 26 + 5 * k)
                n = 25 + 5 * k;
            chk("sda delay", 8'(25 + 5 * k), 8'(n));
            sdl = 0;
            hs = 0;
            repeat (2) @(negedge core_clk);
            hs = 1;
            wt(sda_oe, 1'b0, 60, n);
            hs = 0;
        end
        wr(8'h06, 8'h02);
        wt(bfree, 1'b1, 80, n);
        chk("fast timeout", 8'h01, {7'h0, n > 44 && n < 58});
        chk("bus free", 8'h01, {7'h0, bfree});
        run = 1;
        repeat (16) @(negedge core_clk);
        run = 0;
        chk("bus free", 8'h00, {7'h0, bfree});
        hd = 1;
        wt(brcv, 1'b1, 80, n);
        chk("recovery", 8'h01, {7'h0, brcv});
        p = 0;
        for (n = 0; n < 10000 && brcv === 1'b1; n++)
        begin
            o = scl;
            @(negedge core_clk);
            p += int'(!o && scl);
        end
        hd = 0;
        chk("recovery pulses", 8'd9, 8'(p));
        wr(8'h06, 8'h00);
        hd = 1;
        wt(brcv, 1'b1, 150, n);
        chk("slow early", 8'h00, {7'h0, brcv});
        wt(brcv, 1'b1, 100, n);
        chk("slow timeout", 8'h01, {7'h0, brcv});
        wr(8'h06, 8'h01);
        repeat (300) @(negedge core_clk);
        chk("disabled", 8'h00, {6'h0, brcv, scl_oe});
        chk("open drain", 8'h00, {6'h0, so, sdo});
        // Block bit now clear, so a remote write must land
        wr(8'h08, 8'h24, 1'b1);
        rd(8'h08, 8'h24);
        repeat (2) @(negedge core_clk);
        chk("pending", 8'h00, 8'(rq_q.size() + fq.size()));
        wrap_up;
    end
endmodule
`default_nettype wire
